// file: rtl/sense_fifo_pkg.sv
/*
 Constants, types and register layout of the sample FIFO readout block.
 Assumes a single 100 MHz clock and an I2C host that keeps to the read sequence.
*/
package sense_fifo_pkg;
  localparam int FIFO_DEPTH = 64;
  localparam int FIFO_WIDTH = 32;
  localparam int BUF_DEPTH = 16;
  localparam logic [7:0] REG_CURRENT = 8'h0c;
  localparam logic [7:0] REG_VOLTAGE = 8'h0e;
  localparam logic [7:0] REG_COMBINED = 8'h10;
  localparam logic [7:0] REG_FIFO_CFG = 8'h0a;
  localparam logic [7:0] REG_INT_MASK = 8'h14;
  // Arbitrary bus address value
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a;
  // Status and mask bit positions
  localparam int MSK_WAKE = 0;
  localparam int MSK_CONV = 1;
  localparam int MSK_OCUR = 2;
  localparam int MSK_OVOLT = 3;
  localparam int MSK_UVOLT = 4;
  localparam int MSK_TIMEOUT = 5;
  localparam int MSK_ALARM = 6;
  localparam int MSK_OVERFLOW = 7;
  localparam logic [7:0] MASK_RESET = 8'hff;
  localparam logic [5:0] THRESH_RESET = 6'h34;
  localparam logic [1:0] SEL_CURRENT = 2'b00;
  localparam logic [1:0] SEL_VOLTAGE = 2'b01;
  localparam logic [1:0] SEL_BOTH = 2'b10;
  localparam int SIGN_BIT = 12;
  localparam int MAG_W = 12;

  typedef struct packed {
    logic flush;
    logic rollover;
    logic [5:0] thresh;
    logic [5:0] unused;
    logic [1:0] sel;
  } cfg_t;

  localparam cfg_t CFG_RESET = '{flush: 1'b0, rollover: 1'b0,
    thresh: THRESH_RESET, unused: 6'h00, sel: SEL_CURRENT};

  // Voltage in the upper half, current in the lower
  typedef struct packed {
    logic [15:0] volt;
    logic [15:0] cur;
  } sample_t;

  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_SACK, S_WRB, S_TX, S_MACK
  } i2c_state_t;
endpackage

// file: rtl/sense_fifo_readout.sv
/*
 Sample FIFO readout: input buffer, 64-word sample store, I2C register slave.
 Assumes samples and status flags come from logic on clk_i; SCL and SDA from pins.
*/
`timescale 1ns/1ns
module sample_buffer #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("sample_buffer depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q, cnt_d;
  logic rdy_q;
  logic push, pull;

  assign push = in_valid_i & rdy_q;
  assign pull = out_valid_o & out_ready_i;
  assign out_valid_o = cnt_q != '0;
  assign out_data_o = mem_q[rp_q];
  assign in_ready_o = rdy_q;

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pull) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pull && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b1;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pull) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_d;
      // Registered ready keeps the source's combinational path short
      rdy_q <= cnt_d != (AW+1)'(DEPTH);
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) mem_q[wp_q] <= in_data_i;
  end
endmodule // sample_buffer

module sense_fifo_readout import sense_fifo_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int BDEPTH = BUF_DEPTH
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic sample_valid_i,
  input wire sample_t sample_i,
  output logic sample_ready_o,
  input wire logic [7:0] status_i,
  output logic alert_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("sense_fifo_readout depth must be a power of two");
  end

  logic scl_s1_q, scl_s2_q, scl_s3_q, sda_s1_q, sda_s2_q, sda_s3_q;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  i2c_state_t st_q;
  logic [2:0] bit_q;
  logic [7:0] sr_q, ptr_q;
  logic [31:0] tx_q;
  logic got_q, rw_q, first_q, wb_q, nack_q, vld_q, oe_q, pop_q;
  logic flush_q, alert_q;
  cfg_t cfg_q;
  logic [7:0] mask_q;
  logic wr_en, lat_ev;
  logic bvalid, bready, st_wr, full;
  sample_t bdata, wdata, head;
  logic [31:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_q;

  function automatic logic [15:0] fmt_cur(input logic v, input logic [15:0] c);
    return {v, {3{c[SIGN_BIT]}}, c[MAG_W-1:0]};
  endfunction
  function automatic logic [15:0] fmt_volt(input logic v, input logic [15:0] x);
    return {v, 3'h0, x[MAG_W-1:0]};
  endfunction
  function automatic logic is_data(input logic [7:0] p);
    return p == REG_CURRENT || p == REG_VOLTAGE || p == REG_COMBINED;
  endfunction
  // Words are left-aligned so bytes always leave from the top, MSB first
  function automatic logic [31:0] rd_val(input logic [7:0] p, input logic v,
                                         input sample_t h, input cfg_t c,
                                         input logic [7:0] m);
    logic [15:0] cw;
    cw = fmt_cur(v, h.cur);
    case (p)
      REG_CURRENT: rd_val = {cw, 16'h0000};
      REG_VOLTAGE: rd_val = {fmt_volt(v, h.volt), 16'h0000};
      REG_COMBINED: rd_val = {fmt_volt(v, h.volt), 1'b0, cw[14:0]};
      REG_FIFO_CFG: rd_val = {c, 16'h0000};
      REG_INT_MASK: rd_val = {m, 24'h000000};
      default: rd_val = 32'h00000000;
    endcase
  endfunction
  // Pin synchronisers; only the second and third stages feed logic
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {scl_s3_q, scl_s2_q, scl_s1_q} <= 3'h7;
      {sda_s3_q, sda_s2_q, sda_s1_q} <= 3'h7;
    end else begin
      {scl_s3_q, scl_s2_q, scl_s1_q} <= {scl_s2_q, scl_s1_q, scl_i};
      {sda_s3_q, sda_s2_q, sda_s1_q} <= {sda_s2_q, sda_s1_q, sda_i};
    end
  end
  assign scl_rise = scl_s2_q & ~scl_s3_q;
  assign scl_fall = ~scl_s2_q & scl_s3_q;
  assign bus_start = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  assign bus_stop = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
  assign wr_en = scl_fall && st_q == S_WRB && got_q && !first_q;
  assign lat_ev = scl_fall && st_q == S_ADDR && got_q && sr_q[7:1] == DEV_ADDR && sr_q[0];
  // Bus slave: bits are sampled on SCL rise, SDA is changed on SCL fall
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= S_IDLE;
      bit_q <= 3'h0;
      sr_q <= 8'h00;
      ptr_q <= 8'h00;
      tx_q <= 32'h00000000;
      {got_q, rw_q, first_q, wb_q, nack_q, vld_q, oe_q, pop_q} <= 8'h00;
    end else begin
      pop_q <= 1'b0;
      if (bus_start) begin
        st_q <= S_ADDR;
        bit_q <= 3'h0;
        got_q <= 1'b0;
        oe_q <= 1'b0;
      end else if (bus_stop) begin
        st_q <= S_IDLE;
        oe_q <= 1'b0;
      end else if (scl_rise) begin
        unique case (st_q)
          S_ADDR, S_WRB: begin
            sr_q <= {sr_q[6:0], sda_s2_q};
            bit_q <= bit_q + 1'b1;
            got_q <= bit_q == 3'h7;
          end
          S_TX: begin
            tx_q <= {tx_q[30:0], 1'b0};
            bit_q <= bit_q + 1'b1;
            got_q <= bit_q == 3'h7;
          end
          S_MACK: nack_q <= sda_s2_q;
          S_IDLE, S_SACK: ;
        endcase
      end else if (scl_fall) begin
        unique case (st_q)
          S_ADDR: if (got_q) begin
            got_q <= 1'b0;
            if (sr_q[7:1] == DEV_ADDR) begin
              st_q <= S_SACK;
              oe_q <= 1'b1;
              rw_q <= sr_q[0];
              first_q <= ~sr_q[0];
              wb_q <= 1'b0;
              // Snapshot at addressing so a sample landing mid-read cannot tear
              if (sr_q[0]) begin
                tx_q <= rd_val(ptr_q, cnt_q != '0, head, cfg_q, mask_q);
                vld_q <= cnt_q != '0;
              end
            end else begin
              st_q <= S_IDLE;
            end
          end
          S_WRB: if (got_q) begin
            got_q <= 1'b0;
            st_q <= S_SACK;
            oe_q <= 1'b1;
            if (first_q) begin
              ptr_q <= sr_q;
              first_q <= 1'b0;
            end else begin
              wb_q <= ~wb_q;
            end
          end
          S_SACK: begin
            oe_q <= rw_q & ~tx_q[31];
            st_q <= rw_q ? S_TX : S_WRB;
            bit_q <= 3'h0;
          end
          S_TX: begin
            if (got_q) begin
              got_q <= 1'b0;
              st_q <= S_MACK;
              oe_q <= 1'b0;
            end else begin
              oe_q <= ~tx_q[31];
            end
          end
          S_MACK: begin
            // Byte count is left to the host: two for single, four for combined
            if (nack_q) begin
              st_q <= S_IDLE;
              oe_q <= 1'b0;
              pop_q <= is_data(ptr_q) & vld_q;
            end else begin
              st_q <= S_TX;
              bit_q <= 3'h0;
              oe_q <= ~tx_q[31];
            end
          end
          S_IDLE: ;
        endcase
      end
    end
  end
  // Writable registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_q <= CFG_RESET;
      mask_q <= MASK_RESET;
      flush_q <= 1'b0;
    end else begin
      flush_q <= 1'b0;
      if (wr_en && ptr_q == REG_FIFO_CFG && !wb_q) begin
        flush_q <= sr_q[7];
        cfg_q.rollover <= sr_q[6];
        cfg_q.thresh <= sr_q[5:0];
      end
      if (wr_en && ptr_q == REG_FIFO_CFG && wb_q) begin
        cfg_q.sel <= sr_q[1:0];
      end
      if (wr_en && ptr_q == REG_INT_MASK && !wb_q) begin
        mask_q <= sr_q;
      end
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      alert_q <= 1'b0;
    end else begin
      alert_q <= |(status_i & mask_q);
    end
  end
  // Store stalls for a pop or flush, which is what lets the input buffer fill
  assign bready = ~pop_q & ~flush_q;
  assign st_wr = bvalid & bready;
  assign full = cnt_q == FULL_CNT;
  assign head = mem_q[rd_q];
  sample_buffer #(.WIDTH(FIFO_WIDTH), .DEPTH(BDEPTH)) u_buf (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .in_valid_i(sample_valid_i),
    .in_data_i(sample_i),
    .in_ready_o(sample_ready_o),
    .out_valid_o(bvalid),
    .out_data_o(bdata),
    .out_ready_i(bready)
  );
  always_comb begin
    wdata = bdata;
    unique case (cfg_q.sel)
      SEL_CURRENT: wdata.volt = 16'h0000;
      SEL_VOLTAGE: wdata.cur = 16'h0000;
      default: ;
    endcase
  end
  // 64-word sample store
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (flush_q) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (pop_q) begin
      if (cnt_q != '0) begin
        rd_q <= rd_q + 1'b1;
        cnt_q <= cnt_q - 1'b1;
      end
    end else if (st_wr) begin
      if (!full) begin
        wr_q <= wr_q + 1'b1;
        cnt_q <= cnt_q + 1'b1;
      end else if (cfg_q.rollover) begin
        wr_q <= wr_q + 1'b1;
        rd_q <= rd_q + 1'b1;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (st_wr && (!full || cfg_q.rollover)) begin
      mem_q[wr_q] <= wdata;
    end
  end
  // Device never stretches SCL; host throughput is the host's concern
  assign sda_o = 1'b0;
  assign sda_oe_o = oe_q;
  assign alert_o = alert_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_last_nack;
    scl_fall && st_q == S_MACK && nack_q;
  endsequence
  sequence s_data_read;
    s_last_nack ##0 (is_data(ptr_q) && vld_q);
  endsequence
  sequence s_empty_read;
    s_last_nack ##0 (is_data(ptr_q) && !vld_q);
  endsequence
  chk_full_drop: assert property (
    st_wr && full && !cfg_q.rollover |=> cnt_q == FULL_CNT && $stable(wr_q) && $stable(rd_q))
    else $error("sample written while full without rollover");
  chk_roll_over: assert property (
    st_wr && full && cfg_q.rollover |=>
      wr_q == $past(wr_q) + 1'b1 && rd_q == $past(rd_q) + 1'b1 && cnt_q == FULL_CNT)
    else $error("rollover did not overwrite oldest sample");
  chk_flush_empty: assert property (
    flush_q |=> cnt_q == '0 && wr_q == rd_q)
    else $error("flush left data in the store");
  // Compared against the pointer after the NACK edge, so a rollover there cannot confuse it
  chk_pop_advance: assert property (
    s_data_read |=> pop_q ##1 (rd_q == $past(rd_q) + 1'b1))
    else $error("data read did not advance read pointer");
  chk_empty_hold: assert property (
    s_empty_read |=> !pop_q ##1 $stable(rd_q))
    else $error("empty read moved read pointer");
  chk_valid_flag: assert property (
    lat_ev && is_data(ptr_q) |=> tx_q[31] == $past(cnt_q != '0) && vld_q == tx_q[31])
    else $error("valid flag disagrees with store occupancy");
  chk_volt_sign: assert property (
    lat_ev && (ptr_q == REG_VOLTAGE || ptr_q == REG_COMBINED) |=> tx_q[30:28] == 3'h0)
    else $error("voltage sign bits not zero");
  chk_cur_sign: assert property (
    lat_ev && ptr_q == REG_CURRENT |=> tx_q[30:28] == {3{$past(head.cur[SIGN_BIT])}})
    else $error("current sign copies wrong");
  chk_alert_mask: assert property (
    ##1 alert_q == |($past(status_i) & $past(mask_q)))
    else $error("alert not gated by mask");
  chk_ack_release: assert property (
    s_last_nack |=> !oe_q && st_q == S_IDLE)
    else $error("SDA held after host NACK");
endmodule // sense_fifo_readout

// file: verification/i2c_host_model.sv
/*
 I2C host model that writes and reads the sample FIFO registers.
 Assumes the bench resolves SDA with a pull-up and runs clk_i at 100 MHz.
*/
`timescale 1ns/1ns
module i2c_host_model #(
  parameter logic [6:0] ADDR = 7'h00
) (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // Quarter bit in clocks: a bit of 320 ns keeps the bus near 3.1 MHz
  localparam int QTR = 8;
  int nacks = 0;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic q();
    repeat (QTR) @(negedge clk_i);
  endtask
  // SDA only moves while SCL is low, except for START and STOP
  task automatic bit_io(input logic b, output logic r);
    sda_o = b;
    q();
    scl_o = 1'b1;
    q();
    r = sda_i;
    q();
    scl_o = 1'b0;
    q();
  endtask
  task automatic start();
    sda_o = 1'b1;
    q();
    scl_o = 1'b1;
    q();
    sda_o = 1'b0;
    q();
    scl_o = 1'b0;
    q();
  endtask
  task automatic stop();
    sda_o = 1'b0;
    q();
    scl_o = 1'b1;
    q();
    sda_o = 1'b1;
    q();
  endtask
  task automatic xfer(input logic [7:0] b, input logic a, output logic [7:0] r,
                      output logic k);
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r[i]);
    end
    bit_io(a, k);
  endtask
  task automatic head(input logic [7:0] ptr);
    logic [7:0] r;
    logic k;
    start();
    xfer({ADDR, 1'b0}, 1'b1, r, k);
    nacks += int'(k !== 1'b0);
    xfer(ptr, 1'b1, r, k);
    nacks += int'(k !== 1'b0);
  endtask
  task automatic write_reg(input logic [7:0] ptr, input logic [31:0] d, input int n);
    logic [7:0] r;
    logic k;
    head(ptr);
    for (int i = n - 1; i >= 0; i--) begin
      xfer(d[8*i +: 8], 1'b1, r, k);
      nacks += int'(k !== 1'b0);
    end
    stop();
  endtask
  task automatic read_reg(input logic [7:0] ptr, input int n, output logic [31:0] d);
    logic [7:0] r;
    logic k;
    d = '0;
    head(ptr);
    start();
    xfer({ADDR, 1'b1}, 1'b1, r, k);
    nacks += int'(k !== 1'b0);
    // The last byte is refused so the device stops driving before STOP
    for (int i = n - 1; i >= 0; i--) begin
      xfer(8'hff, i == 0, r, k);
      d = {d[23:0], r};
    end
    stop();
  endtask
endmodule // i2c_host_model

// file: verification/test_sense_fifo_readout.sv
/*
 Self-checking bench of the sample FIFO readout over its I2C pins.
 Assumes the host model above and a 4-deep store and buffer.
*/
`timescale 1ns/1ns
module test_sense_fifo_readout import sense_fifo_pkg::*;;
  localparam int STORE = 4;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic scl;
  logic host_sda;
  logic sda_dut;
  logic sda_oe;
  logic sample_ready;
  logic alert;
  logic sample_valid_i = 1'b0;
  sample_t sample_i = '0;
  logic [7:0] status_i = 8'h00;
  logic [31:0] d;
  int errors = 0;
  int checked = 0;
  // Open-drain wire with pull-up: low while either side pulls
  wire logic sda = host_sda & ~(sda_oe & ~sda_dut);

  sense_fifo_readout #(.DEV_ADDR(DEV_ADDR_DEFAULT), .DEPTH(STORE), .BDEPTH(STORE))
    i_sense_fifo_readout (.clk_i(clk_i), .arst_n_i(arst_n_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_dut), .sda_oe_o(sda_oe), .sample_valid_i(sample_valid_i),
    .sample_i(sample_i), .sample_ready_o(sample_ready), .status_i(status_i),
    .alert_o(alert));
  i2c_host_model #(.ADDR(DEV_ADDR_DEFAULT)) i_i2c_host_model (.clk_i(clk_i),
    .sda_i(sda), .scl_o(scl), .sda_o(host_sda));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic final_report();
    if (errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      errors++;
    end
  endtask
  // Junk above the sign and magnitude fields must not leak out
  function automatic sample_t mk(input int k);
    mk.volt = 16'hf000 | 16'(k * 16'h0123);
    mk.cur = {3'b101, 13'(k * 13'h0a55 + 13'h1234)};
  endfunction
  function automatic logic [31:0] exp_comb(input sample_t s);
    return {1'b1, 3'b000, s.volt[11:0], 1'b0, {3{s.cur[12]}}, s.cur[11:0]};
  endfunction
  task automatic cfg(input logic fl, input logic ro, input logic [1:0] sel);
    i_i2c_host_model.write_reg(REG_FIFO_CFG, {16'h0000, fl, ro, THRESH_RESET, 6'h00, sel}, 2);
  endtask
  task automatic push(input int k0, input int n);
    for (int k = k0; k < k0 + n; k++) begin
      @(negedge clk_i);
      sample_valid_i = 1'b1;
      sample_i = mk(k);
      while (sample_ready !== 1'b1) @(negedge clk_i);
    end
    @(negedge clk_i);
    sample_valid_i = 1'b0;
    repeat (8) @(negedge clk_i);
  endtask

  task automatic t_mask();
    i_i2c_host_model.read_reg(REG_INT_MASK, 1, d);
    check(d, 32'h0000_00ff);
    i_i2c_host_model.read_reg(8'h30, 1, d);
    check(d, 32'h0);
    for (int m = 0; m < 8; m++) begin
      i_i2c_host_model.write_reg(REG_INT_MASK, 32'(1 << m), 1);
      for (int i = 0; i < 8; i++) begin
        status_i = 8'(1 << i);
        repeat (2) @(negedge clk_i);
        check({31'h0, alert}, {31'h0, i == m});
      end
    end
    status_i = 8'h00;
  endtask
  task automatic t_full(input logic ro, input int k0);
    cfg(1'b0, ro, SEL_BOTH);
    i_i2c_host_model.read_reg(REG_FIFO_CFG, 2, d);
    check(d, {16'h0000, 1'b0, ro, THRESH_RESET, 6'h00, SEL_BOTH});
    // More than the buffer can hold, so a store that stops draining when full hangs here
    push(k0, 2 * STORE + 2);
    check({31'h0, sample_ready}, 32'h1);
    for (int i = 0; i < STORE; i++) begin
      i_i2c_host_model.read_reg(REG_COMBINED, 4, d);
      check(d, exp_comb(mk(k0 + i + (ro ? STORE + 2 : 0))));
    end
    i_i2c_host_model.read_reg(REG_COMBINED, 4, d);
    check({31'h0, d[31]}, 32'h0);
  endtask
  task automatic t_flush();
    cfg(1'b0, 1'b0, SEL_BOTH);
    push(20, 2);
    cfg(1'b1, 1'b0, SEL_BOTH);
    for (int i = 0; i < 2; i++) begin
      i_i2c_host_model.read_reg(REG_CURRENT, 2, d);
      check({31'h0, d[15]}, 32'h0);
    end
    push(22, 1);
    i_i2c_host_model.read_reg(REG_COMBINED, 4, d);
    check(d, exp_comb(mk(22)));
  endtask
  task automatic t_select();
    sample_t s;
    cfg(1'b0, 1'b0, SEL_CURRENT);
    push(40, 2);
    s = mk(40);
    i_i2c_host_model.read_reg(REG_CURRENT, 2, d);
    check(d, {16'h0, 1'b1, {3{s.cur[12]}}, s.cur[11:0]});
    i_i2c_host_model.read_reg(REG_COMBINED, 4, d);
    check(d, exp_comb(mk(41)) & 32'h8000_ffff);
    cfg(1'b0, 1'b0, SEL_VOLTAGE);
    push(42, 2);
    s = mk(42);
    i_i2c_host_model.read_reg(REG_VOLTAGE, 2, d);
    check(d, {16'h0, 1'b1, 3'b000, s.volt[11:0]});
    i_i2c_host_model.read_reg(REG_COMBINED, 4, d);
    check(d, exp_comb(mk(43)) & 32'hffff_8000);
    cfg(1'b0, 1'b0, 2'b11);
    push(44, 1);
    i_i2c_host_model.read_reg(REG_COMBINED, 4, d);
    check(d, exp_comb(mk(44)));
  endtask

  initial begin
    repeat (12) @(negedge clk_i);
    arst_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    t_mask();
    t_full(1'b0, 0);
    t_full(1'b1, 10);
    t_flush();
    t_select();
    check(32'(i_i2c_host_model.nacks), 32'h0);
    final_report();
  end
  // Whole run needs about 60000 cycles
  initial begin
    repeat (95000) @(posedge clk_i);
    errors++;
    final_report();
  end
endmodule // test_sense_fifo_readout
